/* design/ser_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SER_REGS_SVH
`define SER_REGS_SVH
`define SER_OFS_EVCFG      8'h04
`define SER_OFS_NTH_LO     8'h05
`define SER_OFS_NTH_HI     8'h06
`define SER_OFS_LTH_LOU    8'h07
`define SER_OFS_LTH_SHR    8'h08
`define SER_OFS_LTH_HIL    8'h09
`define SER_OFS_NRES       8'h0a
`define SER_OFS_LRES_HI    8'h0b
`define SER_OFS_LRES_LO    8'h0c
`define SER_OFS_AMBIR      8'h0d
`define SER_OFS_SRST       8'h0e
`define SER_BIT_NFLAG      7
`define SER_BIT_DROP       4
`define SER_BIT_LFLAG      3
`define SER_BIT_COMBINE    0
`define SER_RST_EVCFG      8'h10
`define SER_RST_NTH_LO     8'h00
`define SER_RST_NTH_HI     8'hff
`define SER_RST_LTH_LOU    8'h00
`define SER_RST_LTH_SHR    8'h0f
`define SER_RST_LTH_HIL    8'hff
`define SER_RST_SRST       8'h00
`define SER_CMD_SRST       8'h38
`define SER_SRST_CYCLES    4'h4
`endif

/* design/ser_pkg.sv */
// Types shared by the sensor event and result register block.
package ser_pkg;
   typedef logic [7:0] ser_byte_t;
   typedef enum logic {
      SER_HYST,
      SER_WINDOW
   } ser_scheme_e;
endpackage

/* design/ser_persist.sv */
// Consecutive-event counter that qualifies one event source.
`timescale 1ns/10ps
module ser_persist (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Measurement result.
   input  wire logic       meas_done,
   input  wire logic       meas_hit,
   input  wire logic [1:0] persist_code,
   // Qualified event.
   output logic            qualified
);
   typedef struct packed {
      logic [3:0] count;
      logic       qual;
   } ser_persist_s;

   ser_persist_s state_reg;
   ser_persist_s state_next;

   function automatic logic [3:0] need(input logic [1:0] code);
      need = 4'h1 << code;
   endfunction

   always_comb begin
      state_next = state_reg;
      if (meas_done) begin
         if (!meas_hit) begin
            state_next.count = 4'h0;
            state_next.qual  = 1'b0;
         end else begin
            if (state_reg.count < need(persist_code)) begin
               state_next.count = state_reg.count + 4'h1;
            end
            // The pin waits for the configured number of hits in a row.
            state_next.qual = (state_reg.count + 4'h1) >= need(persist_code);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign qualified = state_reg.qual;
endmodule // ser_persist

/* design/ser_regs.sv */
// Event configuration, thresholds, results and soft reset register block.
`timescale 1ns/10ps
`include "ser_regs.svh"

// Behaviour
// - Bit 7 of event register reads the proximity event flag.
// - Proximity persistence bits 6:5 need 1, 2, 4 or 8 consecutive events.
// - Bit 3 of event register reads the light event flag.
// - Light persistence bits 2:1 need 1, 2, 4 or 8 events, independently.
// - Combine bit 0 set needs both events for the pin, else either.
// - Supply dropout sets bit 4; one means a brown-out was seen.
// - Supply dropout never drives the interrupt pin.
// - Proximity thresholds at 0x05 and 0x06 reset to 0x00 and 0xff.
// - Light thresholds are two 12-bit values over 0x07 to 0x09.
// - Light low threshold is 0x07 then upper nibble of 0x08.
// - Light high threshold is lower nibble of 0x08 then 0x09.
// - Proximity result reads unsigned at 0x0a.
// - Light result low byte at 0x0c, top nibble at 0x0b right-justified.
// - Bits 7:1 of 0x0d give ambient infrared during proximity phase.
// - Bit 0 of 0x0d shows washout.
// - Writing 0x38 to 0x0e starts soft reset; 0x00 is normal.
// - Light flag sets when count lies outside the thresholds.
// - Hysteresis: proximity flag sets above high, clears below low.
// - Writing zero to a flag bit clears that flag.
// - Pin goes low only after the configured consecutive count.
module ser_regs (
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            srst,
   // Register port.
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   output logic [7:0]           reg_rdata,
   // Proximity engine.
   input  wire logic            near_done,
   input  wire logic [7:0]      near_count,
   input  wire logic [6:0]      ambient_ir_level,
   input  wire logic            washout_status,
   input  wire logic            near_compare_scheme,
   // Light engine.
   input  wire logic            light_done,
   input  wire logic [11:0]     light_count,
   // Supply monitor.
   input  wire logic            supply_dropout,
   // Interrupt pin, open drain.
   input  wire logic            int_n_in,
   output logic                 int_n_out,
   output logic                 int_n_oe,
   // Soft reset request to the rest of the sensor.
   output logic                 soft_reset_active
);
   typedef struct packed {
      logic [1:0]  drop_sync;
      logic        near_flag;
      logic [1:0]  near_persist;
      logic        drop_flag;
      logic        light_flag;
      logic [1:0]  light_persist;
      logic        combine;
      logic [7:0]  nth_lo;
      logic [7:0]  nth_hi;
      logic [7:0]  lth_lou;
      logic [7:0]  lth_shr;
      logic [7:0]  lth_hil;
      logic [7:0]  near_res;
      logic [11:0] light_res;
      logic [7:0]  ambir;
      logic [7:0]  srst_cmd;
      logic [3:0]  srst_cnt;
      logic [7:0]  rdata;
      logic        int_low;
   } ser_regs_s;

   ser_regs_s state_reg;
   ser_regs_s state_next;
   logic      near_qual;
   logic      light_qual;
   logic      near_hit;
   logic      light_hit;
   logic      int_srst;

   // ==========================================================
   // Threshold compares
   function automatic logic outside(input logic [11:0] v, input logic [11:0] lo,
                                    input logic [11:0] hi);
      outside = (v < lo) || (v > hi);
   endfunction

   assign light_hit = outside(light_count, {state_reg.lth_lou, state_reg.lth_shr[7:4]},
                              {state_reg.lth_shr[3:0], state_reg.lth_hil});
   assign near_hit = (near_compare_scheme == ser_pkg::SER_WINDOW) ?
                     outside({4'h0, near_count}, {4'h0, state_reg.nth_lo},
                             {4'h0, state_reg.nth_hi}) :
                     (near_count > state_reg.nth_hi);

   assign int_srst = srst || (state_reg.srst_cnt != 4'h0);

   // ==========================================================
   // Persistence counters
   ser_persist u_near_persist (
      .clk          (clk),
      .srst         (int_srst),
      .meas_done    (near_done),
      .meas_hit     (near_hit),
      .persist_code (state_reg.near_persist),
      .qualified    (near_qual)
   );

   ser_persist u_light_persist (
      .clk          (clk),
      .srst         (int_srst),
      .meas_done    (light_done),
      .meas_hit     (light_hit),
      .persist_code (state_reg.light_persist),
      .qualified    (light_qual)
   );

   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.drop_sync = {state_reg.drop_sync[0], supply_dropout};
      if (state_reg.srst_cnt != 4'h0) begin
         state_next.srst_cnt = state_reg.srst_cnt - 4'h1;
      end
      // Host writes land first so that hardware events below win over clears.
      if (reg_wr) begin
         case (reg_addr)
            `SER_OFS_EVCFG: begin
               if (!reg_wdata[`SER_BIT_NFLAG]) begin
                  state_next.near_flag = 1'b0;
               end
               if (!reg_wdata[`SER_BIT_LFLAG]) begin
                  state_next.light_flag = 1'b0;
               end
               if (!reg_wdata[`SER_BIT_DROP]) begin
                  state_next.drop_flag = 1'b0;
               end
               state_next.near_persist  = reg_wdata[6:5];
               state_next.light_persist = reg_wdata[2:1];
               state_next.combine       = reg_wdata[`SER_BIT_COMBINE];
            end
            `SER_OFS_NTH_LO: state_next.nth_lo = reg_wdata;
            `SER_OFS_NTH_HI: state_next.nth_hi = reg_wdata;
            `SER_OFS_LTH_LOU: state_next.lth_lou = reg_wdata;
            `SER_OFS_LTH_SHR: state_next.lth_shr = reg_wdata;
            `SER_OFS_LTH_HIL: state_next.lth_hil = reg_wdata;
            `SER_OFS_SRST: begin
               state_next.srst_cmd = reg_wdata;
               if (reg_wdata == `SER_CMD_SRST) begin
                  state_next.srst_cnt = `SER_SRST_CYCLES;
               end
            end
            default: begin
            end
         endcase
      end
      if (state_reg.drop_sync[1]) begin
         state_next.drop_flag = 1'b1;
      end
      if (light_done) begin
         state_next.light_res = light_count;
         if (light_hit) begin
            state_next.light_flag = 1'b1;
         end
      end
      if (near_done) begin
         state_next.near_res = near_count;
         state_next.ambir    = {ambient_ir_level, washout_status};
         if (near_hit) begin
            state_next.near_flag = 1'b1;
         end else if (near_compare_scheme == ser_pkg::SER_HYST &&
                      near_count < state_reg.nth_lo) begin
            state_next.near_flag = 1'b0;
         end
      end
      // Brown-out is left out of the pin on purpose.
      state_next.int_low = state_reg.combine ? (near_qual && light_qual) :
                           (near_qual || light_qual);
      case (reg_addr)
         `SER_OFS_EVCFG: state_next.rdata = {state_reg.near_flag, state_reg.near_persist,
                                             state_reg.drop_flag, state_reg.light_flag,
                                             state_reg.light_persist,
                                             state_reg.combine};
         `SER_OFS_NTH_LO: state_next.rdata = state_reg.nth_lo;
         `SER_OFS_NTH_HI: state_next.rdata = state_reg.nth_hi;
         `SER_OFS_LTH_LOU: state_next.rdata = state_reg.lth_lou;
         `SER_OFS_LTH_SHR: state_next.rdata = state_reg.lth_shr;
         `SER_OFS_LTH_HIL: state_next.rdata = state_reg.lth_hil;
         `SER_OFS_NRES: state_next.rdata = state_reg.near_res;
         `SER_OFS_LRES_HI: state_next.rdata = {4'h0, state_reg.light_res[11:8]};
         `SER_OFS_LRES_LO: state_next.rdata = state_reg.light_res[7:0];
         `SER_OFS_AMBIR: state_next.rdata = state_reg.ambir;
         `SER_OFS_SRST: state_next.rdata = state_reg.srst_cmd;
         default: state_next.rdata = 8'h00;
      endcase
      if (!reg_rd) begin
         state_next.rdata = state_reg.rdata;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (int_srst) begin
         state_reg          <= '0;
         state_reg.drop_flag <= 1'b1;
         state_reg.nth_lo   <= `SER_RST_NTH_LO;
         state_reg.nth_hi   <= `SER_RST_NTH_HI;
         state_reg.lth_lou  <= `SER_RST_LTH_LOU;
         state_reg.lth_shr  <= `SER_RST_LTH_SHR;
         state_reg.lth_hil  <= `SER_RST_LTH_HIL;
         state_reg.srst_cmd <= `SER_RST_SRST;
         if (!srst) begin
            state_reg.srst_cnt <= state_reg.srst_cnt - 4'h1;
         end
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata         = state_reg.rdata;
   assign int_n_out         = 1'b0;
   assign int_n_oe          = state_reg.int_low;
   assign soft_reset_active = state_reg.srst_cnt != 4'h0;
endmodule // ser_regs

/* tb/ser_regs_assertions.sv */
// Port checker of the event and result register block.
`timescale 1ns/10ps
module ser_regs_assertions (
   // Register block ports.
   input wire logic        clk, srst, reg_wr, reg_rd, near_done, washout_status,
   input wire logic        near_compare_scheme, light_done, supply_dropout, int_n_in,
   input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, near_count,
   input wire logic [6:0]  ambient_ir_level,
   input wire logic [11:0] light_count,
   input wire logic        int_n_out, int_n_oe, soft_reset_active
);
   // ====================
   // Properties.
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_srst_cmd;
      reg_wr && reg_addr == 8'h0e && reg_wdata == 8'h38 && !soft_reset_active;
   endsequence
   sequence s_drop_read;
      supply_dropout [*4] ##1 (supply_dropout && reg_rd && reg_addr == 8'h04);
   endsequence
   chk_pin_low_only: assert property (int_n_out == 1'b0)
      else $error("interrupt pin driven high");
   chk_soft_reset_len: assert property (s_srst_cmd |=> soft_reset_active [*4])
      else $error("soft reset length wrong");
   chk_reset_pin_idle: assert property ($fell(srst) |-> !int_n_oe && !soft_reset_active)
      else $error("pin or soft reset active after reset");
   chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h04 || reg_addr > 8'h0e)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   chk_pin_has_cause: assert property ($rose(int_n_oe) |-> $past(near_done, 2)
      || $past(light_done, 2)) else $error("pin asserted without measurement");
   chk_rdata_holds: assert property (!reg_rd && !reg_wr && !soft_reset_active
      |=> $stable(reg_rdata)) else $error("read data changed without read");
   chk_light_top_zero: assert property (reg_rd && reg_addr == 8'h0b
      |=> reg_rdata[7:4] == 4'h0) else $error("light result top nibble not zero");
   chk_dropout_seen: assert property (s_drop_read |=> reg_rdata[4])
      else $error("dropout flag not set");
endmodule // ser_regs_assertions

bind ser_regs ser_regs_assertions u_chk (.clk(clk), .srst(srst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .near_done(near_done), .washout_status(washout_status),
   .near_compare_scheme(near_compare_scheme), .light_done(light_done),
   .supply_dropout(supply_dropout), .int_n_in(int_n_in), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .near_count(near_count),
   .ambient_ir_level(ambient_ir_level), .light_count(light_count),
   .int_n_out(int_n_out), .int_n_oe(int_n_oe), .soft_reset_active(soft_reset_active));

/* tb/ser_host.sv */
// Host model on the register port, with the pull-up of the interrupt line.
`timescale 1ns/10ps
module ser_host (
   // Clock.
   input  wire logic       clk,
   // Register port.
   output logic            reg_wr, reg_rd,
   output logic [7:0]      reg_addr, reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // Interrupt line.
   input  wire logic       int_n_out, int_n_oe,
   output logic            int_n_in
);
   // ====================
   // Line and accesses.
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   end
   // A released open-drain line floats up to the pull-up level.
   assign int_n_in = int_n_oe ? int_n_out : 1'b1;
   // Flags are cleared by writing zero; released data is inverted so it is never stale.
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
endmodule // ser_host

/* tb/ser_regs_test.sv */
// Self-checking bench of the event and result register block.
`timescale 1ns/10ps
module ser_regs_test;
   typedef struct packed {logic w; logic [7:0] a, d, e;} ser_row_s;
   logic clk = 0, srst = 1, near_done = 0, light_done = 0, wash = 0, drop = 0, scheme = 0;
   logic [7:0]  near_count = 0, q;
   logic [6:0]  ir = 0;
   logic [11:0] light_count = 0;
   logic        reg_wr, reg_rd, int_n_in, int_n_out, int_n_oe, sra;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   int          n_errors = 0, n_checks = 0;
   ser_row_s rows [11] = '{'{0, 8'h04, 0, 8'h10}, '{0, 8'h05, 0, 0}, '{0, 8'h06, 0, 8'hff},
      '{0, 8'h07, 0, 0}, '{0, 8'h08, 0, 8'h0f}, '{0, 8'h09, 0, 8'hff}, '{0, 8'h0e, 0, 0},
      '{1, 8'h05, 8'ha5, 8'ha5}, '{1, 8'h08, 8'h3c, 8'h3c}, '{1, 8'h0a, 8'h55, 0},
      '{1, 8'h20, 8'h77, 0}};
   // ====================
   // Design, host and clock.
   initial forever #2 clk = ~clk;
   ser_regs u_ser_regs (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .near_done(near_done), .near_count(near_count), .ambient_ir_level(ir),
      .washout_status(wash), .near_compare_scheme(scheme), .light_done(light_done),
      .light_count(light_count), .supply_dropout(drop), .int_n_in(int_n_in),
      .int_n_out(int_n_out), .int_n_oe(int_n_oe), .soft_reset_active(sra));
   ser_host u_ser_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_n_out(int_n_out),
      .int_n_oe(int_n_oe), .int_n_in(int_n_in));
   task automatic chk(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, e);
      u_ser_host.rd(a, q);
      chk($sformatf("reg %h", a), q, e);
   endtask
   // The pin lags the done pulse by two edges, so settle past both first.
   task automatic fire(input logic n, l);
      @(posedge clk);
      near_done <= n;
      light_done <= l;
      @(posedge clk);
      near_done <= 0;
      light_done <= 0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      tally_and_finish;
   end
   // ====================
   // Scenarios.
   initial begin
      repeat (5) @(posedge clk);
      srst <= 0;
      foreach (rows[i]) begin
         if (rows[i].w) u_ser_host.wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      u_ser_host.wr(8'h04, 8'h00);
      rd_chk(8'h04, 8'h00);
      drop <= 1;
      repeat (5) @(posedge clk);
      rd_chk(8'h04, 8'h10);
      drop <= 0;
      chk("pin", {7'h0, int_n_oe}, 0);
      // Let the dropout synchroniser drain, or its last set beats the clear below.
      repeat (3) @(posedge clk);
      u_ser_host.wr(8'h04, 8'h02);
      u_ser_host.wr(8'h07, 8'h10);
      u_ser_host.wr(8'h08, 8'h02);
      u_ser_host.wr(8'h09, 8'h00);
      light_count <= 12'h300;
      fire(0, 1);
      chk("pin", {7'h0, int_n_oe}, 0);
      rd_chk(8'h04, 8'h0a);
      fire(0, 1);
      chk("pin", {7'h0, int_n_oe}, 1);
      rd_chk(8'h0b, 8'h03);
      rd_chk(8'h0c, 8'h00);
      light_count <= 12'h180;
      fire(0, 1);
      chk("pin", {7'h0, int_n_oe}, 0);
      u_ser_host.wr(8'h04, 8'h02);
      rd_chk(8'h04, 8'h02);
      u_ser_host.wr(8'h05, 8'h40);
      u_ser_host.wr(8'h06, 8'h80);
      u_ser_host.wr(8'h04, 8'h01);
      near_count <= 8'h90;
      ir <= 7'h55;
      wash <= 1;
      fire(1, 0);
      chk("pin", {7'h0, int_n_oe}, 0);
      rd_chk(8'h0a, 8'h90);
      rd_chk(8'h0d, 8'hab);
      light_count <= 12'h300;
      fire(0, 1);
      chk("pin", {7'h0, int_n_oe}, 1);
      rd_chk(8'h04, 8'h89);
      u_ser_host.wr(8'h0e, 8'h38);
      #1 chk("soft reset", {7'h0, sra}, 1);
      repeat (6) @(posedge clk);
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h0e, 8'h00);
      // A count under the low threshold only hits in window mode.
      scheme <= 1;
      u_ser_host.wr(8'h05, 8'h40);
      u_ser_host.wr(8'h06, 8'h80);
      near_count <= 8'h20;
      fire(1, 0);
      chk("pin", {7'h0, int_n_oe}, 1);
      rd_chk(8'h04, 8'h90);
      tally_and_finish;
   end
endmodule // ser_regs_test
